// file: shared/comp_pkg.sv
package comp_pkg;
    // Clock and command timing
    localparam int CLK_HZ     = 100_000_000;
    localparam int EXEC_MS    = 1;
    localparam int STOP_MS    = 500;
    localparam int PERSIST_MS = 800;
    // Command codes
    localparam logic [15:0] CMD_SET_OFS  = 16'h241d;
    localparam logic [15:0] CMD_GET_OFS  = 16'h2318;
    localparam logic [15:0] CMD_SET_ALT  = 16'h2427;
    localparam logic [15:0] CMD_GET_ALT  = 16'h2322;
    localparam logic [15:0] CMD_STOP     = 16'h3f86;
    localparam logic [15:0] CMD_START    = 16'h21b1;
    localparam logic [15:0] CMD_AMB_PRES = 16'he000;
    localparam logic [15:0] CMD_PERSIST  = 16'h3615;
    // Reset defaults: 4 degC offset, 0 m altitude
    localparam int          DEF_OFS_DEGC = 4;
    localparam logic [15:0] DEF_OFS_W    = 16'((DEF_OFS_DEGC * 65536 + 87) / 175);
    localparam logic [15:0] DEF_ALT_W    = 16'h0000;
    // Pressure reference for gas compensation, hPa
    localparam logic [16:0] REF_HPA      = 17'h003f5;
    localparam int          ALT_SHIFT    = 3;
    localparam int          GAS_SHIFT    = 10;
    // Checksum over one word
    localparam logic [7:0]  CRC_POLY     = 8'h31;
    localparam logic [7:0]  CRC_INIT     = 8'hff;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CMD     = 8'h00;
    localparam logic [7:0]  ADDR_PARAM   = 8'h04;
    localparam logic [7:0]  ADDR_RESP    = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
    localparam logic [7:0]  ADDR_SETTING = 8'h10;
    // Status bit positions
    localparam int ST_BUSY_B   = 0;
    localparam int ST_PERIOD_B = 1;
    localparam int ST_RESPV_B  = 2;
    localparam int ST_CRCERR_B = 3;
    localparam int ST_REJ_B    = 4;
    localparam int ST_AMB_B    = 5;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef struct packed {
        logic [15:0] offset;
        logic [15:0] altitude;
    } settings_type;

    typedef struct packed {
        logic [15:0] gas;
        logic [15:0] temp;
        logic [15:0] hum;
    } meas_type;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_type;
endpackage

// file: hdl/comp_settings.sv
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// - Settings are changed or read back only while the sensor is idle.
// - Without a stored value the temperature offset starts at four degC.
// - New settings live in working memory until the persist command saves them.
// - Set offset 0x241d takes word plus checksum; 175*word/2^16 degC; 1 ms.
// - Get offset 0x2318 answers offset word and checksum after 1 ms.
// - Set altitude 0x2427 takes metres word plus checksum; 1 ms.
// - Get altitude 0x2322 answers altitude word and checksum after 1 ms.
// - Without a stored value the altitude starts at zero metres.
// - Offset corrects temperature and humidity only, never the gas result.
// - Gas result is compensated from the pressure or altitude in use.
// - While measuring only stop and ambient pressure are taken.
// - Stop 0x3f86 returns to idle within 500 ms.
// - Ambient pressure, once written, replaces altitude as pressure source.
module comp_settings
    import comp_pkg::*;
#(
    parameter int EXEC_CYC    = EXEC_MS * (CLK_HZ / 1000),
    parameter int STOP_CYC    = STOP_MS * (CLK_HZ / 1000),
    parameter int PERSIST_CYC = PERSIST_MS * (CLK_HZ / 1000)
) (
    input  logic         aclk,
    input  logic         aresetn,
    input  logic [7:0]   awaddr,
    input  logic         awvalid,
    output logic         awready,
    input  logic [31:0]  wdata,
    input  logic [3:0]   wstrb,
    input  logic         wvalid,
    output logic         wready,
    output logic [1:0]   bresp,
    output logic         bvalid,
    input  logic         bready,
    input  logic [7:0]   araddr,
    input  logic         arvalid,
    output logic         arready,
    output logic [31:0]  rdata,
    output logic [1:0]   rresp,
    output logic         rvalid,
    input  logic         rready,
    input  settings_type nv_data,
    input  logic         nv_valid,
    output logic         nv_wr_en,
    output settings_type nv_wr_data,
    input  meas_type     raw_meas,
    output meas_type     comp_meas,
    output logic         measuring
);
    // Checksum over one word, high byte first
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ w[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // Commands that touch settings and need idle
    function automatic logic is_setting(input logic [15:0] c);
        return (c == CMD_SET_OFS) || (c == CMD_GET_OFS) || (c == CMD_SET_ALT)
            || (c == CMD_GET_ALT) || (c == CMD_PERSIST);
    endfunction

    state_type    state_q;
    settings_type set_q;
    logic [15:0]  cmd_q;
    logic [31:0]  timer_q;
    logic [23:0]  param_q;
    logic [15:0]  resp_w_q;
    logic [7:0]   resp_crc_q;
    logic         resp_v_q;
    logic         periodic_q;
    logic         crc_err_q;
    logic         reject_q;
    logic [15:0]  amb_q;
    logic         amb_v_q;
    logic [7:0]   aw_q;
    logic         aw_v_q;
    logic [31:0]  w_q;
    logic [3:0]   ws_q;
    logic         w_v_q;
    logic         bvalid_q;
    logic [1:0]   bresp_q;
    logic         rvalid_q;
    logic [31:0]  rdata_q;
    logic [1:0]   rresp_q;
    meas_type     comp_q;
    logic         nv_wr_q;

    logic        wr_fire;
    logic        cmd_fire;
    logic        stat_wr;
    logic        accept;
    logic        crc_ok;
    logic        exec_end;
    logic [15:0] new_cmd;

    // Write address and data may arrive in either order
    assign awready  = !aw_v_q && !bvalid_q;
    assign wready   = !w_v_q && !bvalid_q;
    assign wr_fire  = aw_v_q && w_v_q && !bvalid_q;
    assign new_cmd  = w_q[15:0];
    assign cmd_fire = wr_fire && (aw_q == ADDR_CMD) && (ws_q[1:0] == 2'b11);
    assign stat_wr  = wr_fire && (aw_q == ADDR_STATUS) && ws_q[0];
    assign crc_ok   = crc8(param_q[15:0]) == param_q[23:16];
    assign exec_end = (state_q == ST_EXEC) && (timer_q == 32'h0);

    // Busy, or a settings command during measuring, is refused
    always_comb begin
        accept = 1'b0;
        if (state_q == ST_IDLE) begin
            if (periodic_q) begin
                accept = (new_cmd == CMD_STOP) || (new_cmd == CMD_AMB_PRES);
            end else begin
                accept = is_setting(new_cmd) || (new_cmd == CMD_START)
                      || (new_cmd == CMD_STOP) || (new_cmd == CMD_AMB_PRES);
            end
        end
        // Parameter words must carry a matching checksum
        if ((new_cmd == CMD_SET_OFS) || (new_cmd == CMD_SET_ALT)
                || (new_cmd == CMD_AMB_PRES)) begin
            accept = accept && crc_ok;
        end
    end

    // Bus write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_v_q <= 1'b0;
            w_v_q  <= 1'b0;
            aw_q   <= 8'h00;
            w_q    <= 32'h0;
            ws_q   <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_q   <= awaddr;
                aw_v_q <= 1'b1;
            end
            if (wvalid && wready) begin
                w_q   <= wdata;
                ws_q  <= wstrb;
                w_v_q <= 1'b1;
            end
            if (wr_fire) begin
                aw_v_q <= 1'b0;
                w_v_q  <= 1'b0;
            end
        end
    end

    // Write response; unmapped or read-only addresses answer DECERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (aw_q == ADDR_CMD || aw_q == ADDR_PARAM || aw_q == ADDR_STATUS)
                        ? RESP_OKAY : RESP_DECERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Parameter word and checksum, byte lanes honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            param_q <= 24'h0;
        end else if (wr_fire && aw_q == ADDR_PARAM) begin
            for (int b = 0; b < 3; b++) begin
                if (ws_q[b]) begin
                    param_q[8*b +: 8] <= w_q[8*b +: 8];
                end
            end
        end
    end

    // Command sequencer; stored settings load once after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_LOAD;
            cmd_q   <= 16'h0;
            timer_q <= 32'h0;
        end else begin
            unique case (state_q)
                ST_LOAD: begin
                    state_q <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (cmd_fire && accept) begin
                        cmd_q   <= new_cmd;
                        state_q <= ST_EXEC;
                        if (new_cmd == CMD_STOP) begin
                            timer_q <= 32'(STOP_CYC - 1);
                        end else if (new_cmd == CMD_PERSIST) begin
                            timer_q <= 32'(PERSIST_CYC - 1);
                        end else begin
                            timer_q <= 32'(EXEC_CYC - 1);
                        end
                    end
                end
                ST_EXEC: begin
                    if (timer_q == 32'h0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
            endcase
        end
    end

    // Working settings: defaults, stored copy, then accepted set commands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            set_q <= '{offset: DEF_OFS_W, altitude: DEF_ALT_W};
        end else if (state_q == ST_LOAD && nv_valid) begin
            set_q <= nv_data;
        end else if (exec_end && cmd_q == CMD_SET_OFS) begin
            set_q.offset <= param_q[15:0];
        end else if (exec_end && cmd_q == CMD_SET_ALT) begin
            set_q.altitude <= param_q[15:0];
        end
    end

    // Only the persist command reaches nonvolatile storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_wr_q <= 1'b0;
        end else begin
            nv_wr_q <= exec_end && (cmd_q == CMD_PERSIST);
        end
    end

    // Read-back word with its checksum, valid after execution time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            resp_w_q   <= 16'h0;
            resp_crc_q <= 8'h00;
            resp_v_q   <= 1'b0;
        end else if (exec_end && (cmd_q == CMD_GET_OFS || cmd_q == CMD_GET_ALT)) begin
            resp_w_q   <= (cmd_q == CMD_GET_OFS) ? set_q.offset : set_q.altitude;
            resp_crc_q <= crc8((cmd_q == CMD_GET_OFS) ? set_q.offset : set_q.altitude);
            resp_v_q   <= 1'b1;
        end else if (cmd_fire) begin
            resp_v_q <= 1'b0;
        end
    end

    // Measuring mode and ambient pressure source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periodic_q <= 1'b0;
            amb_q      <= 16'h0;
            amb_v_q    <= 1'b0;
        end else begin
            if (cmd_fire && accept && new_cmd == CMD_START) begin
                periodic_q <= 1'b1;
            end
            if (exec_end && cmd_q == CMD_STOP) begin
                periodic_q <= 1'b0;
            end
            if (exec_end && cmd_q == CMD_AMB_PRES) begin
                amb_q   <= param_q[15:0];
                amb_v_q <= 1'b1;
            end
        end
    end

    // Sticky error flags; a new event wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_err_q <= 1'b0;
            reject_q  <= 1'b0;
        end else begin
            if (stat_wr && w_q[ST_CRCERR_B]) begin
                crc_err_q <= 1'b0;
            end
            if (stat_wr && w_q[ST_REJ_B]) begin
                reject_q <= 1'b0;
            end
            // Only a refused set command blames its checksum; stale parameters do not
            if (cmd_fire && !accept && !crc_ok && state_q == ST_IDLE
                    && (new_cmd == CMD_SET_OFS || new_cmd == CMD_SET_ALT
                        || new_cmd == CMD_AMB_PRES)) begin
                crc_err_q <= 1'b1;
            end
            if (cmd_fire && !accept) begin
                reject_q <= 1'b1;
            end
        end
    end

    // Read channel; one word per request
    assign arready = !rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            unique case (araddr)
                ADDR_CMD:     rdata_q <= {16'h0, cmd_q};
                ADDR_PARAM:   rdata_q <= {8'h00, param_q};
                ADDR_RESP:    rdata_q <= {8'h00, resp_crc_q, resp_w_q};
                ADDR_STATUS:  rdata_q <= {26'h0, amb_v_q, reject_q, crc_err_q,
                                          resp_v_q, periodic_q, state_q != ST_IDLE};
                ADDR_SETTING: rdata_q <= set_q;
                default: begin
                    rdata_q <= 32'h0;
                    rresp_q <= RESP_DECERR;
                end
            endcase
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Output compensation; pressure deviation scales the gas reading
    logic signed [16:0] dp;
    logic signed [33:0] prod;
    logic signed [24:0] gas_sum;
    logic        [16:0] hum_sum;
    assign dp      = amb_v_q ? $signed(REF_HPA - {1'b0, amb_q})
                             : $signed({4'h0, set_q.altitude[15:ALT_SHIFT]});
    assign prod    = $signed({1'b0, raw_meas.gas}) * dp;
    assign gas_sum = $signed({9'h0, raw_meas.gas}) + $signed({prod[33], prod[33:GAS_SHIFT]});
    assign hum_sum = {1'b0, raw_meas.hum} + {3'h0, set_q.offset[15:2]};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_q <= '0;
        end else begin
            comp_q.temp <= (raw_meas.temp > set_q.offset)
                           ? raw_meas.temp - set_q.offset : 16'h0;
            comp_q.hum  <= hum_sum[16] ? 16'hffff : hum_sum[15:0];
            comp_q.gas  <= gas_sum[24] ? 16'h0 : (|gas_sum[23:16] ? 16'hffff
                                                                 : gas_sum[15:0]);
        end
    end

    assign bvalid     = bvalid_q;
    assign bresp      = bresp_q;
    assign rvalid     = rvalid_q;
    assign rdata      = rdata_q;
    assign rresp      = rresp_q;
    assign nv_wr_en   = nv_wr_q;
    assign nv_wr_data = set_q;
    assign comp_meas  = comp_q;
    assign measuring  = periodic_q;

    // Checks on command handling and compensation
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_default_offset: assert property (state_q == ST_LOAD && !nv_valid |=> set_q.offset == DEF_OFS_W)
        else $error("offset default wrong");
    a_default_alt: assert property (state_q == ST_LOAD && !nv_valid |=> set_q.altitude == 16'h0)
        else $error("altitude default wrong");
    a_persist_only: assert property (nv_wr_en |-> $past(exec_end) && cmd_q == CMD_PERSIST)
        else $error("storage written without persist");
    a_crc_discard: assert property (cmd_fire && state_q == ST_IDLE && !crc_ok
        && (new_cmd == CMD_SET_OFS || new_cmd == CMD_SET_ALT)
        |=> state_q == ST_IDLE && crc_err_q ##1 $stable(set_q))
        else $error("bad checksum accepted");
    a_busy_reject: assert property (cmd_fire && periodic_q
        && is_setting(new_cmd) |=> reject_q && $stable(set_q)
        && !(state_q == ST_EXEC && $past(state_q) == ST_IDLE))
        else $error("settings command taken while measuring");
    a_resp_crc: assert property ($rose(resp_v_q) |-> resp_crc_q == crc8(resp_w_q))
        else $error("response checksum wrong");
    a_get_time: assert property (cmd_fire && accept && new_cmd == CMD_GET_OFS
        |=> timer_q == 32'(EXEC_CYC - 1))
        else $error("read-back time wrong");
    a_set_apply: assert property (exec_end && cmd_q == CMD_SET_ALT
        |=> set_q.altitude == $past(param_q[15:0]))
        else $error("altitude not applied");
    a_stop_idle: assert property (exec_end && cmd_q == CMD_STOP |=> !measuring)
        else $error("stop did not end measuring");
    a_temp_only: assert property ($changed(set_q.offset) && $stable(raw_meas.gas)
        && $stable(dp) ##1 $stable(raw_meas.gas) |=> $stable(comp_meas.gas))
        else $error("offset disturbed gas output");

    c_get_offset: cover property (exec_end && cmd_q == CMD_GET_OFS ##1 resp_v_q);
    c_crc_reject: cover property (cmd_fire && !crc_ok && new_cmd == CMD_SET_ALT);
    c_stop_run:   cover property (measuring ##[1:10] cmd_fire && new_cmd == CMD_STOP);
endmodule

// file: verif/nv_store_model.sv
`timescale 1ns/1ps
// Nonvolatile copy of the settings, empty until the first persist
module nv_store_model
    import comp_pkg::*;
(
    input  logic         aclk,
    input  logic         nv_wr_en,
    input  settings_type nv_wr_data,
    output settings_type nv_data,
    output logic         nv_valid
);
    settings_type mem_q;
    logic         full_q;

    initial begin
        mem_q = '0;
        full_q = 1'b0;
    end

    // Capture only on the write pulse, so unsaved edits are lost at reset
    always @(posedge aclk) begin
        if (nv_wr_en === 1'b1) begin
            mem_q <= nv_wr_data;
            full_q <= 1'b1;
        end
    end

    // An empty store shows all ones so a stray load is never a clean zero
    assign nv_data  = full_q ? mem_q : ~mem_q;
    assign nv_valid = full_q;
endmodule

// file: verif/compensation_settings_cmds_bench.sv
`timescale 1ns/1ps
module compensation_settings_cmds_bench;
    import comp_pkg::*;
    logic         aclk;
    logic         aresetn;
    logic [7:0]   awaddr;
    logic         awvalid;
    logic         awready;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         wvalid;
    logic         wready;
    logic [1:0]   bresp;
    logic         bvalid;
    logic [7:0]   araddr;
    logic         arvalid;
    logic         arready;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         rvalid;
    settings_type nv_data;
    logic         nv_valid;
    logic         nv_wr_en;
    settings_type nv_wr_data;
    meas_type     raw_meas;
    meas_type     comp_meas;
    logic         measuring;
    int           err_count;
    int           n_checks;
    int           n_pulse;
    logic [15:0]  alt;

    // Short counts keep the run small; expectations never depend on them
    comp_settings #(.EXEC_CYC(20), .STOP_CYC(40), .PERSIST_CYC(60)) dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
        .nv_data(nv_data), .nv_valid(nv_valid), .nv_wr_en(nv_wr_en),
        .nv_wr_data(nv_wr_data), .raw_meas(raw_meas), .comp_meas(comp_meas),
        .measuring(measuring));

    nv_store_model store (.aclk(aclk), .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data),
        .nv_data(nv_data), .nv_valid(nv_valid));

    always #5 aclk = ~aclk;

    // Count persist pulses as seen by the store
    always @(posedge aclk) begin
        if (nv_wr_en === 1'b1) begin
            n_pulse++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic timeout;
        check("wait finished", 32'h0, 32'h1);
        summarize();
    endtask

    // Both channels offered together, each dropped once taken; bready stays high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                break;
            end
        end
        if (i == 50) begin
            timeout();
        end
        r = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                break;
            end
        end
        if (i == 50) begin
            timeout();
        end
        d = rdata;
        r = rresp;
    endtask

    // Parameter first, then the code, then poll busy until it drops
    task automatic cmd(input logic [15:0] code, input logic [23:0] prm, output logic [31:0] s);
        logic [1:0] r;
        int i;
        wr(ADDR_PARAM, {8'h00, prm}, r);
        wr(ADDR_CMD, {16'h0000, code}, r);
        for (i = 0; i < 100; i++) begin
            rd(ADDR_STATUS, s, r);
            if (s[ST_BUSY_B] === 1'b0) begin
                break;
            end
        end
        if (i == 100) begin
            timeout();
        end
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    task automatic t_defaults;
        logic [31:0] d;
        logic [1:0]  r;
        rd(ADDR_SETTING, d, r);
        check("default settings", d, {16'h05da, 16'h0000});
        check("gas at zero altitude", comp_meas.gas, 16'h0400);
        check("temp with offset", comp_meas.temp, 16'h0a26);
        check("hum with offset", comp_meas.hum, 16'h2176);
        rd(8'h14, d, r);
        check("unmapped read resp", r, RESP_DECERR);
        check("unmapped read data", d, 32'h0);
        wr(ADDR_RESP, 32'h1, r);
        check("read-only write resp", r, RESP_DECERR);
        // A code written without both low byte lanes must not start anything
        wstrb <= 4'h1;
        wr(ADDR_CMD, {16'h0000, CMD_START}, r);
        wstrb <= 4'hf;
        check("half-strobe command ignored", measuring, 1'b0);
    endtask

    // Every set and get code, with words and checksums from known examples
    task automatic t_set_get;
        logic [31:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        logic [23:0] tbl [4];
        tbl = '{24'h4807e6, 24'h630912, 24'h09079e, 24'h42044c};
        for (int k = 0; k < 4; k++) begin
            cmd(k < 2 ? CMD_SET_OFS : CMD_SET_ALT, tbl[k], s);
            if (k >= 2) begin
                alt = tbl[k][15:0];
            end
            rd(ADDR_SETTING, d, r);
            check("stored word", k < 2 ? d[31:16] : d[15:0], tbl[k][15:0]);
            check("gas ignores offset", comp_meas.gas, 16'h0400 + (alt >> 3));
            cmd(k < 2 ? CMD_GET_OFS : CMD_GET_ALT, 24'h0, s);
            check("response ready", s[ST_RESPV_B], 1'b1);
            rd(ADDR_RESP, d, r);
            check("response word", d[23:0], tbl[k]);
        end
        check("temp after offset", comp_meas.temp, 16'h06ee);
    endtask

    task automatic t_bad_crc;
        logic [31:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        cmd(16'h1234, 24'h0, s);
        check("unknown code refused", s[ST_REJ_B -: 2], 2'b10);
        wr(ADDR_STATUS, 32'h18, r);
        cmd(CMD_SET_ALT, 24'h000123, s);
        check("checksum error flag", s[ST_CRCERR_B], 1'b1);
        rd(ADDR_SETTING, d, r);
        check("altitude kept", d, {16'h0912, 16'h044c});
        wr(ADDR_STATUS, 32'h18, r);
        rd(ADDR_STATUS, d, r);
        check("sticky cleared", d[4:3], 2'b00);
    endtask

    // While measuring a set is refused but ambient pressure is taken
    task automatic t_measuring;
        logic [31:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        cmd(CMD_START, 24'h0, s);
        check("measuring on", measuring, 1'b1);
        cmd(CMD_SET_OFS, 24'h4807e6, s);
        check("reject flag", s[ST_REJ_B], 1'b1);
        rd(ADDR_SETTING, d, r);
        check("offset kept", d, {16'h0912, 16'h044c});
        cmd(CMD_AMB_PRES, 24'h4203db, s);
        check("ambient in use", s[ST_AMB_B], 1'b1);
        check("gas from ambient", comp_meas.gas, 16'h041a);
        cmd(CMD_STOP, 24'h0, s);
        check("measuring off", measuring, 1'b0);
        wr(ADDR_STATUS, 32'h18, r);
    endtask

    // Persisted values return after reset, later unsaved edits do not
    task automatic t_persist;
        logic [31:0] s;
        logic [31:0] d;
        logic [1:0]  r;
        cmd(CMD_PERSIST, 24'h0, s);
        // The pulse trails the end of execution; let the counter see it
        repeat (2) @(posedge aclk);
        check("persist pulses", n_pulse, 1);
        cmd(CMD_SET_ALT, 24'h09079e, s);
        do_reset();
        rd(ADDR_SETTING, d, r);
        check("persisted settings", d, {16'h0912, 16'h044c});
        cmd(CMD_START, 24'h0, s);
        check("measuring again", measuring, 1'b1);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hf;
        wvalid = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        raw_meas = {16'h0400, 16'h1000, 16'h2000};
        err_count = 0;
        n_checks = 0;
        n_pulse = 0;
        alt = 16'h0000;
        do_reset();
        t_defaults();
        t_set_get();
        t_bad_crc();
        t_measuring();
        t_persist();
        summarize();
    end
endmodule
